// ==== uart_lmc_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the line and modem control block.
// Assumes a byte-wide register port with a three-bit offset.
`ifndef UART_LMC_REGS_VH
`define UART_LMC_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_DATA 3'h0
`define OFF_IER 3'h1
`define OFF_EFR 3'h2
`define OFF_LCR 3'h3
`define OFF_MCR 3'h4
`define OFF_LSR 3'h5
`define OFF_MSR 3'h6
`define OFF_SPR 3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LCR_PAR_EN 3
`define LCR_EVEN 4
`define LCR_FORCE 5
`define LCR_BREAK 6
`define LCR_DIV 7
`define MCR_TERM 0
`define MCR_RTS 1
`define MCR_OUT1 2
`define MCR_OUT2 3
`define MCR_LOOP 4
`define MCR_ANY 5
`define MCR_THR_EN 6
`define MCR_PRESC 7
`define EFR_ENH 4
`define IER_MODEM 3

// ----------------------------------------------------------------
// Reset values and special codes
// ----------------------------------------------------------------
`define LCR_RESET 8'h05
`define SPR_RESET 8'hFF
`define ZERO_RESET 8'h00
`define LCR_ENH_KEY 8'hBF
`define FIFO_RDY_SEL 2'h1

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define PRESCALE_DIV 3'h4

`endif

// ==== uart_rx_store.v ====
// Small receive character store with registered read data.
// Assumes one writer and one reader on the same clock; a write to the address being read is bypassed.
`timescale 1ns/1ps

module uart_rx_store #(
    parameter WIDTH = 11,
    parameter AW = 6
) (
    input wire mclk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [WIDTH-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [WIDTH-1:0] rdata_q
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (we && (waddr == raddr)) begin
            rdata_q <= wdata;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule // uart_rx_store

// ==== uart_line_modem_control.v ====
// Line control, modem control, line status and modem status logic of one serial channel.
// Assumes a receiver and transmitter on mclk that report characters and take bytes as single-cycle pulses.
`timescale 1ns/1ps
`include "uart_lmc_regs.vh"

//Contract
// - Parity is odd or even by select bit; forced parity gives mark or space.
// - Break bit holds serial output low until software clears it.
// - Divisor-access bit redirects data register offsets to the divisor latches.
// - Modem control bit 0 drives terminal-ready pin inverted; starts high.
// - Offset 7 selects ready register, trigger level or scratchpad by bits.
// - Enhanced feature register is reached only while line control holds 0xBF.
// - Output-1 bit feeds the internal ring indicator during loopback.
// - Interrupt-output enable drives interrupt-enable output and sets output-2 low.
// - Modem control bit 4 selects internal loopback; clear means normal.
// - Resume-on-any: any character resumes; flow characters are not stored.
// - Offset 6 is threshold control when enhanced and threshold enables set.
// - Writes to modem control bits 5 to 7 need enhanced enable.
// - Prescaler bit divides the generator clock by four.
// - Line status bit 0 shows at least one received character waiting.
// - Character arriving while full sets overrun and is discarded.
// - Parity and framing flags belong to the head character.
// - Break flagged per frame of low line; one break character stored.
// - Holding-empty flag set when holding empties, cleared on host load.
// - Transmitter-empty flag only when holding and shift register empty.
// - FIFO error flag stands while any stored byte carries an error.
// - Input changes set delta flags, ring indicator only on its trailing edge; enabled modem interrupt follows.
// - Upper modem status bits show inverted pins or, in loopback, outputs.
module uart_line_modem_control #(
    parameter AW = 6
) (
    input wire mclk,
    input wire rst,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata_q,
    input wire rx_valid,
    input wire [7:0] rx_char,
    input wire rx_par_bit,
    input wire rx_stop_ok,
    input wire rx_is_flow_char,
    input wire tx_load,
    input wire tx_shift_busy,
    input wire tx_serial,
    input wire clear_to_send_in_n,
    input wire data_set_ready_in_n,
    input wire ring_indicator_in_n,
    input wire carrier_detect_in_n,
    output reg tx_out_q,
    output reg [7:0] tx_byte_q,
    output reg tx_parity_q,
    output reg thr_valid_q,
    output reg [7:0] line_format_q,
    output reg [15:0] divisor_q,
    output reg brg_tick_q,
    output reg tx_resume_q,
    output reg terminal_ready_n_q,
    output reg rts_n_q,
    output reg user_output_two_n_q,
    output reg int_out_q,
    output reg int_oe_q
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Parity bit for a character of the programmed length.
    function par_of;
        input [7:0] d;
        input [7:0] line_format_control;
        reg [7:0] m;
        begin
            m = d & (8'h1F | {line_format_control[1:0] == 2'h3, line_format_control[1:0] >= 2'h2, line_format_control[1:0] != 2'h0, 5'h00});
            if (line_format_control[`LCR_FORCE]) begin
                par_of = ~line_format_control[`LCR_EVEN];
            end else begin
                par_of = (^m) ^ ~line_format_control[`LCR_EVEN];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [7:0] lcr_q;
    reg [7:0] mcr_q;
    reg [7:0] efr_q;
    reg [7:0] ier_q;
    reg [7:0] tcr_q;
    reg [7:0] tlr_q;
    reg [7:0] spr_q;
    reg [7:0] div_lo_q;
    reg [7:0] div_hi_q;
    reg overrun_q;
    reg thr_full_q;
    reg head_tag_en_q;
    reg break_hold_q;
    reg [3:0] delta_q;
    reg [3:0] prev_q;
    reg [1:0] presc_q;
    reg [AW:0] cnt_q;
    reg [AW:0] err_cnt_q;
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [3:0] s2_q;
    reg [3:0] s3_q;
    reg [3:0] pin_q;
    wire [10:0] head;

    wire enh_key = (lcr_q == `LCR_ENH_KEY);
    wire enh = efr_q[`EFR_ENH];
    wire loopback = mcr_q[`MCR_LOOP];
    wire sel_tcr = ~enh_key & enh & mcr_q[`MCR_THR_EN];
    wire sel_rdy = ~enh_key & ({loopback, mcr_q[`MCR_OUT1]} == `FIFO_RDY_SEL);
    wire sel_tlr = ~enh_key & ~sel_rdy & enh & mcr_q[`MCR_THR_EN];
    wire data_sel = ~lcr_q[`LCR_DIV];
    wire rx_any = (cnt_q != {(AW+1){1'b0}});
    wire full = cnt_q[AW];

    // ----------------------------------------------------------------
    // Modem inputs: synchronised, then chosen from pins or loopback
    // ----------------------------------------------------------------
    wire [3:0] pins_n = {carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n};
    reg [3:0] s1v_q;
    integer i;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1v_q <= 4'hF;
            s2_q <= 4'hF;
            s3_q <= 4'hF;
            pin_q <= 4'hF;
        end else begin
            s1v_q <= pins_n;
            s2_q <= s1v_q;
            s3_q <= s2_q;
            for (i = 0; i < 4; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
        end
    end

    // Loopback order is carrier, ring, data-set-ready, clear-to-send.
    wire [3:0] loop_in = {mcr_q[`MCR_OUT2], mcr_q[`MCR_OUT1], mcr_q[`MCR_TERM], mcr_q[`MCR_RTS]};
    wire [3:0] modem_in = loopback ? loop_in : ~pin_q;
    wire [7:0] msr_val = {modem_in, delta_q};

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    wire wr_data = wr & (addr == `OFF_DATA);
    wire pop = rd & (addr == `OFF_DATA) & data_sel & rx_any;
    wire rd_lsr = rd & (addr == `OFF_LSR) & ~enh_key;
    wire rd_msr = rd & (addr == `OFF_MSR) & ~enh_key & ~sel_tcr;
    wire thr_wr = wr_data & data_sel;

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    wire rx_pe = lcr_q[`LCR_PAR_EN] & (rx_par_bit != par_of(rx_char, lcr_q));
    wire rx_brk = ~rx_stop_ok & (rx_char == 8'h00) & ~rx_par_bit;
    wire rx_fe = ~rx_stop_ok & ~rx_brk;
    wire sw_flow = (efr_q[3:0] != 4'h0);
    wire rx_keep = rx_valid & ~(sw_flow & rx_is_flow_char) & ~(rx_brk & break_hold_q);
    wire push = rx_keep & ~full;
    wire push_err = rx_pe | rx_fe | rx_brk;
    wire head_err = head[10] | head[9] | head[8];
    wire [AW-1:0] raddr = pop ? rd_ptr_q + {{(AW-1){1'b0}}, 1'b1} : rd_ptr_q;
    wire [7:0] lsr_val = {err_cnt_q != {(AW+1){1'b0}}, ~thr_full_q & ~tx_shift_busy, ~thr_full_q,
                          {head[10:8] & {3{head_tag_en_q & rx_any}}}, overrun_q, rx_any};

    uart_rx_store #(
        .WIDTH(11),
        .AW(AW)
    ) u_store (
        .mclk(mclk),
        .we(push),
        .waddr(wr_ptr_q),
        .wdata({rx_brk, rx_fe, rx_pe, rx_char}),
        .raddr(raddr),
        .rdata_q(head)
    );

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= {(AW+1){1'b0}};
            err_cnt_q <= {(AW+1){1'b0}};
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            overrun_q <= 1'b0;
            head_tag_en_q <= 1'b0;
            break_hold_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= raddr;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
            if ((push & push_err) & ~(pop & head_err)) begin
                err_cnt_q <= err_cnt_q + {{AW{1'b0}}, 1'b1};
            end else if ((pop & head_err) & ~(push & push_err)) begin
                err_cnt_q <= err_cnt_q - {{AW{1'b0}}, 1'b1};
            end
            if (rx_valid & full) begin
                overrun_q <= 1'b1;
            end else if (rd_lsr) begin
                overrun_q <= 1'b0;
            end
            if (pop | (push & ~rx_any)) begin
                head_tag_en_q <= 1'b1;
            end else if (rd_lsr) begin
                head_tag_en_q <= 1'b0;
            end
            if (rx_valid) begin
                break_hold_q <= rx_brk;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            lcr_q <= `LCR_RESET;
            mcr_q <= `ZERO_RESET;
            efr_q <= `ZERO_RESET;
            ier_q <= `ZERO_RESET;
            tcr_q <= `ZERO_RESET;
            tlr_q <= `ZERO_RESET;
            spr_q <= `SPR_RESET;
            div_lo_q <= `ZERO_RESET;
            div_hi_q <= `ZERO_RESET;
        end else if (wr) begin
            case (addr)
                `OFF_DATA: begin
                    if (~data_sel) begin
                        div_lo_q <= wdata;
                    end
                end
                `OFF_IER: begin
                    if (~data_sel) begin
                        div_hi_q <= wdata;
                    end else begin
                        ier_q <= wdata;
                    end
                end
                `OFF_EFR: begin
                    if (enh_key) begin
                        efr_q <= wdata;
                    end
                end
                `OFF_LCR: begin
                    lcr_q <= wdata;
                end
                `OFF_MCR: begin
                    if (~enh_key) begin
                        mcr_q[4:0] <= wdata[4:0];
                        if (enh) begin
                            mcr_q[7:5] <= wdata[7:5];
                        end
                    end
                end
                `OFF_MSR: begin
                    if (sel_tcr) begin
                        tcr_q <= wdata;
                    end
                end
                `OFF_SPR: begin
                    if (sel_tlr) begin
                        tlr_q <= wdata;
                    end else if (~sel_rdy & ~enh_key) begin
                        spr_q <= wdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Transmit holding and modem status
    // ----------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            thr_full_q <= 1'b0;
            tx_byte_q <= 8'h00;
            delta_q <= 4'h0;
            prev_q <= 4'h0;
        end else begin
            if (thr_wr) begin
                thr_full_q <= 1'b1;
                tx_byte_q <= wdata;
            end else if (tx_load) begin
                thr_full_q <= 1'b0;
            end
            prev_q <= modem_in;
            // A change in the same cycle as the read stays flagged.
            delta_q[0] <= (modem_in[0] != prev_q[0]) | (delta_q[0] & ~rd_msr);
            delta_q[1] <= (modem_in[1] != prev_q[1]) | (delta_q[1] & ~rd_msr);
            delta_q[2] <= (prev_q[2] & ~modem_in[2]) | (delta_q[2] & ~rd_msr);
            delta_q[3] <= (modem_in[3] != prev_q[3]) | (delta_q[3] & ~rd_msr);
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                `OFF_DATA: rdata_q <= data_sel ? head[7:0] : div_lo_q;
                `OFF_IER: rdata_q <= data_sel ? ier_q : div_hi_q;
                `OFF_EFR: rdata_q <= enh_key ? efr_q : 8'h00;
                `OFF_LCR: rdata_q <= lcr_q;
                `OFF_MCR: rdata_q <= enh_key ? 8'h00 : mcr_q;
                `OFF_LSR: rdata_q <= enh_key ? 8'h00 : lsr_val;
                `OFF_MSR: rdata_q <= enh_key ? 8'h00 : (sel_tcr ? tcr_q : msr_val);
                `OFF_SPR: begin
                    if (enh_key) begin
                        rdata_q <= 8'h00;
                    end else if (sel_rdy) begin
                        rdata_q <= {6'h00, ~thr_full_q, rx_any};
                    end else if (sel_tlr) begin
                        rdata_q <= tlr_q;
                    end else begin
                        rdata_q <= spr_q;
                    end
                end
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_out_q <= 1'b1;
            tx_parity_q <= 1'b0;
            thr_valid_q <= 1'b0;
            line_format_q <= `LCR_RESET;
            divisor_q <= 16'h0000;
            brg_tick_q <= 1'b0;
            presc_q <= 2'h0;
            tx_resume_q <= 1'b0;
            terminal_ready_n_q <= 1'b1;
            rts_n_q <= 1'b1;
            user_output_two_n_q <= 1'b1;
            int_out_q <= 1'b0;
            int_oe_q <= 1'b0;
        end else begin
            tx_out_q <= lcr_q[`LCR_BREAK] ? 1'b0 : tx_serial;
            tx_parity_q <= par_of(tx_byte_q, lcr_q);
            thr_valid_q <= thr_full_q;
            line_format_q <= lcr_q;
            divisor_q <= {div_hi_q, div_lo_q};
            if (mcr_q[`MCR_PRESC]) begin
                presc_q <= presc_q + 2'h1;
                brg_tick_q <= (presc_q == `PRESCALE_DIV - 3'h1);
            end else begin
                presc_q <= 2'h0;
                brg_tick_q <= 1'b1;
            end
            tx_resume_q <= mcr_q[`MCR_ANY] & rx_valid;
            terminal_ready_n_q <= ~mcr_q[`MCR_TERM];
            rts_n_q <= ~mcr_q[`MCR_RTS];
            user_output_two_n_q <= ~mcr_q[`MCR_OUT2];
            int_oe_q <= mcr_q[`MCR_OUT2];
            int_out_q <= ier_q[`IER_MODEM] & (delta_q != 4'h0);
        end
    end

endmodule // uart_line_modem_control

// ==== uart_lmc_chk.sv ====
// Concurrent checks on the ports of the line and modem control block.
// Assumes one clock mclk and the asynchronous active-high reset rst.
`timescale 1ns/1ps
`include "uart_lmc_regs.vh"
module uart_lmc_chk (
    input wire mclk,
    input wire rst,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata_q,
    input wire rx_valid,
    input wire tx_out_q,
    input wire tx_parity_q,
    input wire [7:0] line_format_q,
    input wire [15:0] divisor_q,
    input wire brg_tick_q,
    input wire tx_resume_q,
    input wire terminal_ready_n_q,
    input wire rts_n_q,
    input wire user_output_two_n_q,
    input wire int_oe_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadow of the last accepted modem control write; the age saturates once the pins have settled.
    reg [3:0] mcr_sh_q;
    reg [1:0] age_q;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            mcr_sh_q <= 4'h0;
            age_q <= 2'h3;
        end else if (wr && addr == `OFF_MCR && line_format_q != `LCR_ENH_KEY) begin
            mcr_sh_q <= wdata[3:0];
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    a_div_low: assert property (wr && addr == `OFF_DATA && line_format_q[`LCR_DIV]
        |=> ##1 divisor_q[7:0] == $past(wdata, 2)) else $error("divisor low byte not loaded");
    a_efr_hidden: assert property (rd && addr == `OFF_EFR && line_format_q != `LCR_ENH_KEY
        |=> rdata_q == 8'h00) else $error("feature register visible without key");
    a_locked_zero: assert property (rd && addr[2] && line_format_q == `LCR_ENH_KEY
        |=> rdata_q == 8'h00) else $error("upper offsets readable under key");
    a_break_low: assert property (line_format_q[`LCR_BREAK] && $past(line_format_q[`LCR_BREAK])
        |-> !tx_out_q) else $error("serial output not low during break");
    a_forced_par: assert property (line_format_q[`LCR_PAR_EN] && line_format_q[`LCR_FORCE]
        && $stable(line_format_q) |-> tx_parity_q == !line_format_q[`LCR_EVEN]) else $error("forced parity wrong");
    a_dtr_pin: assert property (age_q == 2'h3 |-> terminal_ready_n_q == !mcr_sh_q[`MCR_TERM])
        else $error("terminal ready pin wrong");
    a_rts_pin: assert property (age_q == 2'h3 |-> rts_n_q == !mcr_sh_q[`MCR_RTS])
        else $error("request to send pin wrong");
    a_op2_pin: assert property (age_q == 2'h3 |-> user_output_two_n_q == !mcr_sh_q[`MCR_OUT2]
        && int_oe_q == mcr_sh_q[`MCR_OUT2]) else $error("output two or interrupt enable wrong");
    a_tick_gap: assert property (!brg_tick_q |-> ##[1:3] brg_tick_q)
        else $error("baud tick gap above four cycles");
    a_resume_cause: assert property (tx_resume_q |-> $past(rx_valid))
        else $error("resume without received character");
endmodule // uart_lmc_chk

bind uart_line_modem_control uart_lmc_chk u_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .rx_valid(rx_valid), .tx_out_q(tx_out_q), .tx_parity_q(tx_parity_q),
    .line_format_q(line_format_q), .divisor_q(divisor_q), .brg_tick_q(brg_tick_q), .tx_resume_q(tx_resume_q),
    .terminal_ready_n_q(terminal_ready_n_q), .rts_n_q(rts_n_q), .user_output_two_n_q(user_output_two_n_q),
    .int_oe_q(int_oe_q));

// ==== modem_line_peer.sv ====
// Behavioural remote modem and receiver front end feeding the line and modem control block.
// Assumes the block samples its inputs on the rising edge of mclk.
`timescale 1ns/1ps
module modem_line_peer (
    output reg rx_valid,
    output reg [7:0] rx_char,
    output reg rx_par_bit,
    output reg rx_stop_ok,
    output reg rx_is_flow_char,
    output reg clear_to_send_in_n,
    output reg data_set_ready_in_n,
    output reg ring_indicator_in_n,
    output reg carrier_detect_in_n,
    input wire mclk
);
    initial begin
        {rx_valid, rx_char, rx_par_bit, rx_stop_ok, rx_is_flow_char} = 12'h000;
        {clear_to_send_in_n, data_set_ready_in_n, ring_indicator_in_n, carrier_detect_in_n} = 4'hF;
    end
    // Between characters the data lines carry the inverse of the last one, so no stale value looks valid.
    task send(input logic [7:0] c, input logic p, input logic s, input logic f);
        @(posedge mclk);
        {rx_valid, rx_char, rx_par_bit, rx_stop_ok, rx_is_flow_char} <= {1'b1, c, p, s, f};
        @(posedge mclk);
        {rx_valid, rx_char, rx_par_bit, rx_stop_ok, rx_is_flow_char} <= {1'b0, ~c, ~p, ~s, ~f};
    endtask
    task pins(input logic [3:0] v);
        @(posedge mclk);
        {clear_to_send_in_n, data_set_ready_in_n, ring_indicator_in_n, carrier_detect_in_n} <= v;
    endtask
endmodule // modem_line_peer

// ==== uart_line_modem_control_tb.sv ====
// Self-checking bench for the line and modem control block with a behavioural line peer.
// Assumes a receive store of four characters (AW=2), so five arrivals overrun it.
`timescale 1ns/1ps
module uart_line_modem_control_tb;
    reg mclk, rst, wr, rd, tx_load, tx_shift_busy, tx_serial;
    reg [2:0] addr;
    reg [7:0] wdata;
    wire rx_valid, rx_par_bit, rx_stop_ok, rx_is_flow_char, cts_n, dsr_n, ri_n, cd_n, thr_valid_q;
    wire [7:0] rx_char, rdata_q, tx_byte_q, line_format_q;
    wire [15:0] divisor_q;
    wire tx_out_q, tx_parity_q, brg_tick_q, tx_resume_q, dtr_n, rts_n, op2_n, int_out_q, int_oe_q;
    int errors, num_checks, i, n;
    logic [18:0] rows [4] = '{{3'h3, 8'h1B, 8'h1B}, {3'h7, 8'h5A, 8'h5A}, {3'h1, 8'h08, 8'h08}, {3'h4, 8'h0B, 8'h0B}};
    logic [8:0] par_rows [4] = '{{8'h0B, 1'b1}, {8'h1B, 1'b0}, {8'h2B, 1'b1}, {8'h3B, 1'b0}};
    uart_line_modem_control #(.AW(2)) uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .rx_valid(rx_valid), .rx_char(rx_char), .rx_par_bit(rx_par_bit), .rx_stop_ok(rx_stop_ok),
        .rx_is_flow_char(rx_is_flow_char), .tx_load(tx_load), .tx_shift_busy(tx_shift_busy), .tx_serial(tx_serial),
        .clear_to_send_in_n(cts_n), .data_set_ready_in_n(dsr_n), .ring_indicator_in_n(ri_n),
        .carrier_detect_in_n(cd_n), .tx_out_q(tx_out_q), .tx_byte_q(tx_byte_q), .tx_parity_q(tx_parity_q),
        .thr_valid_q(thr_valid_q), .line_format_q(line_format_q), .divisor_q(divisor_q), .brg_tick_q(brg_tick_q),
        .tx_resume_q(tx_resume_q), .terminal_ready_n_q(dtr_n), .rts_n_q(rts_n), .user_output_two_n_q(op2_n),
        .int_out_q(int_out_q), .int_oe_q(int_oe_q));
    modem_line_peer peer (.mclk(mclk), .rx_valid(rx_valid), .rx_char(rx_char), .rx_par_bit(rx_par_bit),
        .rx_stop_ok(rx_stop_ok), .rx_is_flow_char(rx_is_flow_char), .clear_to_send_in_n(cts_n),
        .data_set_ready_in_n(dsr_n), .ring_indicator_in_n(ri_n), .carrier_detect_in_n(cd_n));
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task w(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task r(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask = 8'hFF);
        @(posedge mclk);
        {addr, rd} <= {a, 1'b1};
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, rdata_q & mask}, {8'h00, exp});
    endtask
    task ticks(input logic [15:0] exp);
        n = 0;
        repeat (40) begin
            @(posedge mclk);
            #1;
            n = n + (brg_tick_q === 1'b1);
        end
        chk("ticks", n[15:0], exp);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #400000;
        errors = errors + 1;
        end_sim();
    end
    initial begin
        {rst, wr, rd, tx_load, tx_shift_busy, tx_serial, addr, wdata} = {6'b100001, 11'h000};
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("pins", {dtr_n, rts_n, op2_n, int_oe_q, tx_out_q}, 5'b11101);
        r(3'h3, 8'h05);
        r(3'h7, 8'hFF);
        r(3'h4, 8'h00);
        r(3'h5, 8'h60);
        for (i = 0; i < 4; i++) begin
            w(rows[i][18:16], rows[i][15:8]);
            r(rows[i][18:16], rows[i][7:0]);
        end
        repeat (3) @(posedge mclk);
        chk("pins", {dtr_n, rts_n, op2_n, int_oe_q}, 4'b0001);
        w(3'h4, 8'hEB);
        r(3'h4, 8'h0B);
        w(3'h3, 8'h9B);
        w(3'h0, 8'h34);
        w(3'h1, 8'h12);
        r(3'h0, 8'h34);
        chk("divisor", divisor_q, 16'h1234);
        w(3'h3, 8'h1B);
        r(3'h1, 8'h08);
        w(3'h3, 8'hBF);
        w(3'h2, 8'h10);
        r(3'h2, 8'h10);
        r(3'h4, 8'h00);
        w(3'h3, 8'h1B);
        r(3'h2, 8'h00);
        w(3'h4, 8'hC0);
        r(3'h4, 8'hC0);
        ticks(16'd10);
        w(3'h6, 8'h5A);
        r(3'h6, 8'h5A);
        w(3'h7, 8'h33);
        r(3'h7, 8'h33);
        w(3'h4, 8'h04);
        r(3'h7, 8'h02);
        ticks(16'd40);
        w(3'h4, 8'h00);
        r(3'h7, 8'h5A);
        r(3'h6, 8'h00, 8'hF0);
        w(3'h4, 8'h1F);
        r(3'h6, 8'hF0, 8'hF0);
        w(3'h4, 8'h00);
        repeat (8) @(posedge mclk);
        r(3'h6, 8'h0F);
        repeat (2) @(posedge mclk);
        chk("int_out", int_out_q, 1'b0);
        peer.pins(4'b0111);
        for (i = 0; i < 20 && int_out_q !== 1'b1; i++) @(posedge mclk);
        chk("int_out", int_out_q, 1'b1);
        r(3'h6, 8'h11);
        repeat (2) @(posedge mclk);
        chk("int_out", int_out_q, 1'b0);
        r(3'h6, 8'h10);
        w(3'h4, 8'h20);
        peer.send(8'h41, 1'b1, 1'b0, 1'b0);
        #1;
        chk("resume", tx_resume_q, 1'b1);
        peer.send(8'h42, 1'b0, 1'b1, 1'b0);
        r(3'h5, 8'hED);
        r(3'h0, 8'h41);
        r(3'h5, 8'h61);
        r(3'h0, 8'h42);
        r(3'h5, 8'h60);
        for (i = 0; i < 5; i++) peer.send(8'h10 + i[7:0], ^(8'h10 + i[7:0]), 1'b1, 1'b0);
        r(3'h5, 8'h63);
        r(3'h5, 8'h61);
        for (i = 0; i < 4; i++) r(3'h0, 8'h10 + i[7:0]);
        r(3'h5, 8'h60);
        w(3'h3, 8'hBF);
        w(3'h2, 8'h1A);
        w(3'h3, 8'h1B);
        peer.send(8'h13, 1'b1, 1'b1, 1'b1);
        #1;
        chk("resume", tx_resume_q, 1'b1);
        r(3'h5, 8'h60);
        w(3'h3, 8'h5B);
        repeat (3) @(posedge mclk);
        chk("tx_out", tx_out_q, 1'b0);
        w(3'h3, 8'h1B);
        repeat (3) @(posedge mclk);
        chk("tx_out", tx_out_q, 1'b1);
        w(3'h0, 8'hA5);
        r(3'h5, 8'h00);
        chk("tx_byte", {7'h00, thr_valid_q, tx_byte_q}, 16'h01A5);
        for (i = 0; i < 4; i++) begin
            w(3'h3, par_rows[i][8:1]);
            repeat (3) @(posedge mclk);
            chk("tx_parity", tx_parity_q, par_rows[i][0]);
        end
        @(posedge mclk);
        {tx_load, tx_shift_busy} <= 2'b11;
        @(posedge mclk);
        tx_load <= 1'b0;
        r(3'h5, 8'h20);
        @(posedge mclk) tx_shift_busy <= 1'b0;
        r(3'h5, 8'h60);
        end_sim();
    end
endmodule // uart_line_modem_control_tb
